// File: design/sensor_cal_engine.sv
// Per-sensor calibrated flag, calibration request and acquisition delay.
`timescale 1ns/10ps
module sensor_cal_engine
    import touch_cal_pkg::*;
(
    input  wire logic       ref_clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       restore_in,
    input  wire logic       clear_in,
    input  wire logic       scan_ok_in,
    input  wire logic       cal_done_in,
    input  wire logic [4:0] acq_value_in,
    output logic            flag_out,
    output logic            cal_req_out,
    output logic [4:0]      acq_delay_out
);
    logic flag_reg;
    logic flag_next;
    logic [4:0] acq_reg;
    logic [4:0] acq_next;
    wire  done_ok;

    // A finished calibration only counts while one was really requested.
    assign done_ok     = cal_done_in & cal_req_out;
    assign cal_req_out = ~flag_reg & scan_ok_in;

    // Restore forces a new calibration even against a finishing one; a
    // host clear loses to a finishing calibration so the event is kept.
    assign flag_next = restore_in ? FLAG_RESET :
                       done_ok    ? 1'b1 :
                       clear_in   ? 1'b0 :
                       flag_reg;
    assign acq_next  = restore_in ? ACQ_RESET :
                       done_ok    ? acq_value_in :
                       acq_reg;

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            flag_reg <= FLAG_RESET;
            acq_reg  <= ACQ_RESET;
        end else begin
            flag_reg <= flag_next;
            acq_reg  <= acq_next;
        end
    end

    assign flag_out      = flag_reg;
    assign acq_delay_out = acq_reg;
endmodule : sensor_cal_engine

// File: design/touch_cal_pkg.sv
// Package with register map, field positions and waveform codes.
package touch_cal_pkg;
    localparam logic [7:0] RESTORE_ADDR  = 8'h00;
    localparam logic [7:0] RESTORE_VALUE = 8'hFF;
    localparam logic [7:0] CAL0_ADDR     = 8'h01;
    localparam logic [7:0] CAL1_ADDR     = 8'h02;

    localparam int WS_HI   = 7;
    localparam int WS_LO   = 6;
    localparam int FLAG_B  = 1;
    localparam int EN_B    = 0;

    localparam logic [1:0] WS_RESET    = 2'h0;
    localparam logic       FLAG_RESET  = 1'b0;
    localparam logic       EN_RESET    = 1'b1;
    localparam logic [4:0] ACQ_RESET   = 5'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    localparam logic [1:0] WS_NORMAL   = 2'h0;
    localparam logic [1:0] WS_DOUBLE   = 2'h1;
    localparam logic [1:0] WS_HALF     = 2'h2;
    localparam logic [1:0] WS_RESERVED = 2'h3;

    typedef enum logic [1:0] {
        WAVE_NORMAL,
        WAVE_DOUBLE,
        WAVE_HALF
    } waveform_t;
endpackage : touch_cal_pkg

// File: design/touch_sensor_calibration_control.sv
// Two-sensor calibration control registers with calibration handshake.
//
// Summary of operation
// - Host writing zero to a calibrated flag asks for that sensor's recalibration.
// - Device keeps waveform type and flag; sets flag to one when calibration ends.
// - A calibrated flag at zero is a pending calibration request; sensor 1 raises it only while its scan enable is set.
// - Sensor 0 waveform in bits 7:6: normal, double, half; code 11 gives double.
// - Sensor 1 waveform in bits 7:6, same encoding; code 11 gives double.
// - Bits 5:2 of both registers and bit 0 of sensor 0 read zero.
// - Recalibration overwrites the sensor's stored acquisition delay.
// - Writing FF to address 00 restores defaults and recalibrates both sensors.
`timescale 1ns/10ps
module touch_sensor_calibration_control
    import touch_cal_pkg::*;
(
    input  wire logic       ref_clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output logic [7:0]      reg_rdata_out,
    output logic            reg_rvalid_out,
    input  wire logic       sensor0_cal_done_in,
    input  wire logic [4:0] sensor0_acq_value_in,
    input  wire logic       sensor1_cal_done_in,
    input  wire logic [4:0] sensor1_acq_value_in,
    output logic            sensor0_cal_req_out,
    output logic            sensor1_cal_req_out,
    output logic [4:0]      sensor0_acq_delay_out,
    output logic [4:0]      sensor1_acq_delay_out,
    output waveform_t       sensor0_waveform_out,
    output waveform_t       sensor1_waveform_out,
    output logic            sensor0_calibrated_flag_out,
    output logic            sensor1_calibrated_flag_out,
    output logic            sensor1_scan_enable_out
);
    // Reserved code 11 maps onto the double waveform.
    function automatic waveform_t decode_wave(input logic [1:0] code);
        waveform_t w;
        w = WAVE_DOUBLE;
        unique case (code)
            WS_NORMAL:   w = WAVE_NORMAL;
            WS_DOUBLE:   w = WAVE_DOUBLE;
            WS_HALF:     w = WAVE_HALF;
            WS_RESERVED: w = WAVE_DOUBLE;
        endcase
        return w;
    endfunction : decode_wave

    logic [1:0] ws0_reg;
    logic [1:0] ws1_reg;
    logic       en1_reg;
    waveform_t  wave0_reg;
    waveform_t  wave1_reg;
    logic [7:0] rdata_reg;
    logic       rvalid_reg;
    logic [1:0] ws0_next;
    logic [1:0] ws1_next;
    logic       en1_next;
    logic       flag0;
    logic       flag1;

    wire       wr_cal0;
    wire       wr_cal1;
    wire       restore;
    wire       clear0;
    wire       clear1;
    wire [7:0] cal0_view;
    wire [7:0] cal1_view;
    wire [7:0] rd_mux;

    assign wr_cal0 = reg_wr_in & (reg_addr_in == CAL0_ADDR);
    assign wr_cal1 = reg_wr_in & (reg_addr_in == CAL1_ADDR);
    assign restore = reg_wr_in & (reg_addr_in == RESTORE_ADDR)
                   & (reg_wdata_in == RESTORE_VALUE);
    // Writing one to a flag does nothing: only a finished calibration sets it.
    assign clear0  = wr_cal0 & ~reg_wdata_in[FLAG_B];
    assign clear1  = wr_cal1 & ~reg_wdata_in[FLAG_B];

    assign ws0_next = restore ? WS_RESET :
                      wr_cal0 ? reg_wdata_in[WS_HI:WS_LO] : ws0_reg;
    assign ws1_next = restore ? WS_RESET :
                      wr_cal1 ? reg_wdata_in[WS_HI:WS_LO] : ws1_reg;
    assign en1_next = restore ? EN_RESET :
                      wr_cal1 ? reg_wdata_in[EN_B] : en1_reg;

    // Unimplemented positions are built as constant zero.
    assign cal0_view = {ws0_reg, 4'h0, flag0, 1'b0};
    assign cal1_view = {ws1_reg, 4'h0, flag1, en1_reg};
    assign rd_mux    = (reg_addr_in == CAL0_ADDR) ? cal0_view :
                       (reg_addr_in == CAL1_ADDR) ? cal1_view :
                       RDATA_RESET;

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ws0_reg    <= WS_RESET;
            ws1_reg    <= WS_RESET;
            en1_reg    <= EN_RESET;
            wave0_reg  <= WAVE_NORMAL;
            wave1_reg  <= WAVE_NORMAL;
            rdata_reg  <= RDATA_RESET;
            rvalid_reg <= 1'b0;
        end else begin
            ws0_reg    <= ws0_next;
            ws1_reg    <= ws1_next;
            en1_reg    <= en1_next;
            wave0_reg  <= decode_wave(ws0_next);
            wave1_reg  <= decode_wave(ws1_next);
            rvalid_reg <= reg_rd_in;
            if (reg_rd_in) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    // Sensor 0 has no enable, so it is always allowed to calibrate.
    sensor_cal_engine u_cal0 (
        .ref_clk_in    (ref_clk_in),
        .sys_rst_in    (sys_rst_in),
        .restore_in    (restore),
        .clear_in      (clear0),
        .scan_ok_in    (1'b1),
        .cal_done_in   (sensor0_cal_done_in),
        .acq_value_in  (sensor0_acq_value_in),
        .flag_out      (flag0),
        .cal_req_out   (sensor0_cal_req_out),
        .acq_delay_out (sensor0_acq_delay_out)
    );

    // A disabled sensor 1 is not scanned, so its calibration waits.
    sensor_cal_engine u_cal1 (
        .ref_clk_in    (ref_clk_in),
        .sys_rst_in    (sys_rst_in),
        .restore_in    (restore),
        .clear_in      (clear1),
        .scan_ok_in    (en1_reg),
        .cal_done_in   (sensor1_cal_done_in),
        .acq_value_in  (sensor1_acq_value_in),
        .flag_out      (flag1),
        .cal_req_out   (sensor1_cal_req_out),
        .acq_delay_out (sensor1_acq_delay_out)
    );

    assign reg_rdata_out               = rdata_reg;
    assign reg_rvalid_out              = rvalid_reg;
    assign sensor0_waveform_out        = wave0_reg;
    assign sensor1_waveform_out        = wave1_reg;
    assign sensor0_calibrated_flag_out = flag0;
    assign sensor1_calibrated_flag_out = flag1;
    assign sensor1_scan_enable_out     = en1_reg;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    property p_clear_requests;
        (clear0 && !sensor0_cal_done_in && !restore)
            |=> (!flag0 && sensor0_cal_req_out);
    endproperty
    a_clear_requests: assert property (p_clear_requests)
        else $error("Clearing sensor 0 flag did not request calibration.");

    property p_done_sets;
        (sensor1_cal_done_in && sensor1_cal_req_out && !restore) |=> flag1;
    endproperty
    a_done_sets: assert property (p_done_sets)
        else $error("Finished calibration did not set sensor 1 flag.");

    property p_pending_req;
        !flag0 |-> sensor0_cal_req_out;
    endproperty
    a_pending_req: assert property (p_pending_req)
        else $error("Sensor 0 flag low without a calibration request.");

    property p_wave0;
        (wr_cal0 && !restore && reg_wdata_in[WS_HI:WS_LO] == WS_RESERVED)
            |=> (sensor0_waveform_out == WAVE_DOUBLE);
    endproperty
    a_wave0: assert property (p_wave0)
        else $error("Sensor 0 reserved code did not give double waveform.");

    property p_wave1;
        (wr_cal1 && !restore && reg_wdata_in[WS_HI:WS_LO] == WS_HALF)
            |=> (sensor1_waveform_out == WAVE_HALF);
    endproperty
    a_wave1: assert property (p_wave1)
        else $error("Sensor 1 half code did not give half waveform.");

    property p_unimpl_zero;
        (reg_rd_in && reg_addr_in == CAL0_ADDR)
            |=> (reg_rvalid_out && reg_rdata_out[5:2] == 4'h0
                 && !reg_rdata_out[0]);
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("Unimplemented sensor 0 bits read nonzero.");

    property p_scan_off;
        !sensor1_scan_enable_out |-> !sensor1_cal_req_out;
    endproperty
    a_scan_off: assert property (p_scan_off)
        else $error("Sensor 1 calibration requested while scanning disabled.");

    property p_acq_overwrite;
        (sensor0_cal_done_in && sensor0_cal_req_out && !restore)
            |=> (sensor0_acq_delay_out == $past(sensor0_acq_value_in));
    endproperty
    a_acq_overwrite: assert property (p_acq_overwrite)
        else $error("Calibration did not overwrite sensor 0 delay.");

    property p_restore;
        restore |=> (!flag0 && !flag1 && sensor1_scan_enable_out
                     && sensor0_waveform_out == WAVE_NORMAL
                     && sensor1_waveform_out == WAVE_NORMAL);
    endproperty
    a_restore: assert property (p_restore)
        else $error("Restore did not bring back defaults.");

    c_cal0_cycle: cover property (clear0 ##[1:20] flag0);
    c_cal1_wait: cover property (!sensor1_scan_enable_out && !flag1
                                 ##[1:20] sensor1_cal_req_out);
    c_restore: cover property (restore ##1 sensor0_cal_req_out);
endmodule : touch_sensor_calibration_control

// File: sim/analog_cal_model.sv
// Analog calibration side: answers a pending request after a fixed wait.
`timescale 1ns/10ps
module analog_cal_model #(
    parameter int WAIT_CYCLES = 8
) (
    input  wire logic       ref_clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       cal_req_in,
    input  wire logic [4:0] result_in,
    output logic            cal_done_out,
    output logic [4:0]      acq_value_out
);
    int cnt;
    // Outside the done pulse the value is inverted so a stale sample shows.
    assign acq_value_out = cal_done_out ? result_in : ~result_in;
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt          <= 0;
            cal_done_out <= 1'b0;
        end else begin
            cal_done_out <= cal_req_in && !cal_done_out
                            && cnt == WAIT_CYCLES - 1;
            cnt <= (cal_req_in && !cal_done_out) ? cnt + 1 : 0;
        end
    end
endmodule : analog_cal_model

// File: sim/tb_touch_sensor_calibration_control.sv
// Self-checking bench for the calibration control registers.
`timescale 1ns/10ps
module tb_touch_sensor_calibration_control;
    import touch_cal_pkg::*;
    logic       clk, rst, wr, rd, dn0, dn1, rq0, rq1, f0, f1, en1, rv;
    logic [7:0] addr, wd, rdat, v;
    logic [4:0] r0, r1, av0, av1, a0, a1;
    waveform_t  w0, w1;
    int         err_count, num_checks, cycles;

    touch_sensor_calibration_control touch_sensor_calibration_control_i (
        .ref_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr),
        .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdat), .reg_rvalid_out(rv),
        .sensor0_cal_done_in(dn0), .sensor0_acq_value_in(av0),
        .sensor1_cal_done_in(dn1), .sensor1_acq_value_in(av1),
        .sensor0_cal_req_out(rq0), .sensor1_cal_req_out(rq1),
        .sensor0_acq_delay_out(a0), .sensor1_acq_delay_out(a1),
        .sensor0_waveform_out(w0), .sensor1_waveform_out(w1),
        .sensor0_calibrated_flag_out(f0), .sensor1_calibrated_flag_out(f1),
        .sensor1_scan_enable_out(en1));
    analog_cal_model model0_i (.ref_clk_in(clk), .sys_rst_in(rst),
        .cal_req_in(rq0), .result_in(r0), .cal_done_out(dn0),
        .acq_value_out(av0));
    analog_cal_model model1_i (.ref_clk_in(clk), .sys_rst_in(rst),
        .cal_req_in(rq1), .result_in(r1), .cal_done_out(dn1),
        .acq_value_out(av1));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    // The ceiling is about thirty times the length of the whole sequence.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            stop_test();
        end
    end

    task automatic chk(input string what, input logic [7:0] e, g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, d);
        @(posedge clk); #1;
        addr = a;
        wd = d;
        wr = 1'b1;
        @(posedge clk); #1;
        wr = 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, e);
        @(posedge clk); #1;
        addr = a;
        rd = 1'b1;
        @(posedge clk); #1;
        rd = 1'b0;
        chk("read valid", 8'h01, {7'h00, rv});
        chk("read data", e, rdat);
    endtask : rd_chk

    task automatic wait_flag(input int s, input logic [4:0] e);
        int n;
        n = 0;
        while ((s ? f1 : f0) !== 1'b1 && n < 20) begin
            @(posedge clk); #1;
            n++;
        end
        chk("flag", 8'h01, {7'h00, s ? f1 : f0});
        chk("acq delay", {3'h0, e}, {3'h0, s ? a1 : a0});
        chk("request", 8'h00, {7'h00, s ? rq1 : rq0});
    endtask : wait_flag

    task automatic t_reset;
        chk("requests", 8'h03, {6'h00, rq1, rq0});
        rd_chk(CAL0_ADDR, 8'h00);
        rd_chk(CAL1_ADDR, 8'h01);
        wait_flag(0, r0);
        wait_flag(1, r1);
        rd_chk(CAL0_ADDR, 8'h02);
        rd_chk(8'h03, 8'h00);
    endtask : t_reset

    task automatic t_wave;
        for (int c = 0; c < 4; c++) begin
            wr_reg(CAL0_ADDR, {c[1:0], 6'h3F});
            wr_reg(CAL1_ADDR, {c[1:0], 6'h3F});
            v = {6'h00, (c == 3) ? WS_DOUBLE : c[1:0]};
            chk("wave0", v, {6'h00, w0});
            chk("wave1", v, {6'h00, w1});
            rd_chk(CAL0_ADDR, {c[1:0], 6'h02});
            rd_chk(CAL1_ADDR, {c[1:0], 6'h03});
        end
    endtask : t_wave

    task automatic t_recal;
        r0 = 5'h15;
        wr_reg(CAL0_ADDR, 8'h00);
        chk("pending0", 8'h01, {6'h00, f0, rq0});
        wait_flag(0, 5'h15);
    endtask : t_recal

    task automatic t_disable;
        r1 = 5'h0A;
        wr_reg(CAL1_ADDR, 8'h80);
        repeat (12) @(posedge clk);
        #1;
        chk("idle1", 8'h00, {5'h00, en1, f1, rq1});
        wr_reg(CAL1_ADDR, 8'h82);
        chk("flag1 held", 8'h00, {5'h00, en1, f1, rq1});
        wr_reg(CAL1_ADDR, 8'h81);
        chk("resume1", 8'h05, {5'h00, en1, f1, rq1});
        wait_flag(1, 5'h0A);
    endtask : t_disable

    task automatic t_restore;
        wr_reg(RESTORE_ADDR, RESTORE_VALUE);
        chk("restored", 8'h30, {f1, f0, rq1, rq0, w1, w0});
        chk("acq0 cleared", 8'h00, {3'h0, a0});
        chk("acq1 cleared", 8'h00, {3'h0, a1});
        rd_chk(CAL1_ADDR, 8'h01);
        rd_chk(RESTORE_ADDR, 8'h00);
        wait_flag(0, 5'h15);
        wait_flag(1, 5'h0A);
    endtask : t_restore

    initial begin
        {rst, wr, rd, addr, wd} = {1'b1, 18'h00000};
        r0 = 5'h0C;
        r1 = 5'h13;
        err_count = 0;
        num_checks = 0;
        cycles = 0;
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_wave();
        t_recal();
        t_disable();
        t_restore();
        stop_test();
    end
endmodule : tb_touch_sensor_calibration_control
